// ==== shared/epl_pkg.sv ====
// Purpose: shared constants and carriers of the energy pulse and line monitor
// Assumes: 40 MHz clock, 4000 Hz output word rate, 24-bit two's complement fractions
// Notes: register offsets are byte addresses on the classic Wishbone bus
package epl_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int SAMPLE_RATE_HZ = 4000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFF_MODES = 8'h00;
    localparam logic [7:0] OFF_NO_LOAD = 8'h04;
    localparam logic [7:0] OFF_PULSE_DUR = 8'h08;
    localparam logic [7:0] OFF_RATE = 8'h0C;
    localparam logic [7:0] OFF_V1_DUR = 8'h10;
    localparam logic [7:0] OFF_V1_LEV = 8'h14;
    localparam logic [7:0] OFF_I1_DUR = 8'h18;
    localparam logic [7:0] OFF_I1_LEV = 8'h1C;
    localparam logic [7:0] OFF_RATIO = 8'h20;
    localparam logic [7:0] OFF_TRIG = 8'h24;
    localparam logic [7:0] OFF_TEMP = 8'h28;
    localparam logic [7:0] OFF_TEMP_GAIN = 8'h2C;
    localparam logic [7:0] OFF_TEMP_OFFSET = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    localparam logic [7:0] OFF_V2 = 8'h38;
    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int MODES_PIN_B = 0;
    localparam int MODES_PIN_C = 2;
    localparam int MODES_SHARED = 4;
    localparam int MODES_AUTO_FREQ = 6;
    localparam int ST_VOLT1_DIP = 0;
    localparam int ST_CURR1_LOSS = 1;
    localparam int ST_FREQ_UPD = 2;
    localparam int ST_TEMP_UPD = 3;
    localparam logic [23:0] RST_PULSE_DUR = 24'h000001;
    localparam logic [23:0] RST_RATIO = 24'h019999;
    localparam logic [23:0] RST_TEMP_GAIN = 24'h2F03C3;
    localparam logic [23:0] RST_TEMP_OFFSET = 24'hF3D35A;
    localparam logic [2:0] TRIG_START = 3'h1;
    localparam logic [2:0] TRIG_MID = 3'h2;
    localparam logic [2:0] TRIG_LAST = 3'h4;
    localparam logic [1:0] SEL_CODE_SHARED = 2'h3;
    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [23:0] act;
        logic [23:0] app;
        logic [23:0] react;
        logic [23:0] wbr;
    } epl_energy_t;
    typedef struct packed {
        logic [23:0] v1;
        logic [23:0] i1;
        logic [23:0] v2;
        logic [23:0] temp_raw;
    } epl_samples_t;
endpackage : epl_pkg

// ==== rtl/epl_dip_detect.sv ====
// Purpose: majority-vote dip or loss detector for one measured channel
// Assumes: tick_i is a one-cycle sample-rate enable
// Notes: set_o pulses for one cycle at the end of a window that votes low
`timescale 1ns/100ps
module epl_dip_detect
    import epl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sample stream
    input wire logic tick_i,
    input wire logic [23:0] sample_i,
    // settings
    input wire logic [23:0] level_i,
    input wire logic [23:0] duration_i,
    // result
    output logic set_o
);
    typedef struct packed {
        logic [23:0] cnt;
        logic [23:0] above;
        logic [23:0] below;
        logic set;
    } epl_dip_state_t;

    epl_dip_state_t st;
    epl_dip_state_t next_st;
    logic [23:0] rect;
    logic [23:0] next_above;
    logic [23:0] next_below;

    assign rect = sample_i[23] ? 24'(-sample_i) : sample_i;
    assign set_o = st.set;

    always_comb begin
        next_st = st;
        next_st.set = 1'b0;
        next_above = st.above + {23'h000000, rect >= level_i};
        next_below = st.below + {23'h000000, rect < level_i};
        if (duration_i == 24'h000000) begin
            next_st.cnt = 24'h000000;
            next_st.above = 24'h000000;
            next_st.below = 24'h000000;
        end else if (tick_i) begin
            if (st.cnt + 24'h000001 >= duration_i) begin
                next_st.set = next_below > next_above;
                next_st.cnt = 24'h000000;
                next_st.above = 24'h000000;
                next_st.below = 24'h000000;
            end else begin
                next_st.cnt = st.cnt + 24'h000001;
                next_st.above = next_above;
                next_st.below = next_below;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : epl_dip_detect

// ==== rtl/epl_monitor.sv ====
// Purpose: energy pulse pins, no-load clamp, dip and loss detect, ratio and temperature
// Assumes: measurement inputs are synchronous and valid on each sample tick
// Notes: pulse pins are active low; registers are up to 24 bits in the low bits of a word
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module epl_monitor
    import epl_pkg::*;
#(
    parameter int SAMPLE_DIV_P = SAMPLE_DIV
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // measurement results
    input wire epl_energy_t total_i,
    input wire epl_energy_t ch1_i,
    input wire epl_energy_t ch2_i,
    input wire epl_samples_t samples_i,
    input wire logic low_supply_i,
    // pulse pins, active low
    output logic pulse_pin_a_o,
    output logic pulse_pin_b_o,
    output logic pulse_pin_c_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [15:0] div;
        logic [1:0] pin_b_select;
        logic [1:0] pin_c_select;
        logic [1:0] shared_pulse_select;
        logic auto_freq_enable;
        logic [23:0] no_load_threshold;
        logic [23:0] pulse_duration_setting;
        logic [23:0] full_scale_rate_setting;
        logic [23:0] volt1_dip_duration;
        logic [23:0] volt1_dip_level;
        logic [23:0] curr1_loss_duration;
        logic [23:0] curr1_loss_level;
        logic [23:0] ratio;
        logic [2:0] temp_trigger;
        logic [23:0] temp;
        logic [23:0] temp_scale_gain;
        logic [23:0] temp_zero_offset;
        logic [23:0] v2;
        logic [3:0] status;
        logic [2:0][22:0] acc;
        logic [2:0][23:0] wcnt;
        logic [2:0] pins;
        logic [15:0] period;
        logic v1_neg;
    } epl_state_t;

    epl_state_t st;
    epl_state_t next_st;
    logic tick;
    logic wr;
    logic [3:0] evt;
    logic [2:0] is_pulse;
    logic [2:0] lvl;
    logic [2:0][23:0] val;
    logic [2:0][21:0] inc;
    logic [2:0] dip_set;
    logic shared_en;
    logic [23:0] act_nz;
    logic [23:0] react_nz;
    logic [24:0] temp_sum;
    logic [48:0] temp_prod;

    function automatic logic [23:0] clamp_small(input logic [23:0] v, input logic [23:0] t);
        logic [23:0] mag;
        mag = v[23] ? 24'(-v) : v;
        return (mag < t) ? 24'h000000 : v;
    endfunction : clamp_small

    function automatic logic [23:0] type_of(input epl_energy_t e, input logic [1:0] s);
        logic [23:0] r;
        unique case (s)
            2'h0: r = e.act;
            2'h1: r = e.app;
            2'h2: r = e.react;
            2'h3: r = e.wbr;
        endcase
        return r;
    endfunction : type_of

    function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [23:0] r;
        r = old;
        for (int b = 0; b < 3; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ************************************************************
    // source selection per pin
    // ************************************************************
    // energy sign pins show a steady low while either value is negative
    assign shared_en = (st.pin_b_select == SEL_CODE_SHARED);
    assign act_nz = clamp_small(total_i.act, st.no_load_threshold);
    assign react_nz = clamp_small(total_i.react, st.no_load_threshold);

    always_comb begin
        is_pulse = 3'b111;
        lvl = 3'b111;
        val[0] = act_nz;
        val[1] = 24'h000000;
        val[2] = react_nz;
        if (shared_en) begin
            val[0] = type_of(ch1_i, st.shared_pulse_select);
            val[1] = type_of(ch2_i, st.shared_pulse_select);
            if (st.shared_pulse_select != 2'h1) begin
                val[0] = clamp_small(val[0], st.no_load_threshold);
                val[1] = clamp_small(val[1], st.no_load_threshold);
            end
            is_pulse[2] = 1'b0;
            unique case (st.pin_c_select)
                2'h0: lvl[2] = ~low_supply_i;
                2'h1: lvl[2] = ~(val[0][23] | val[1][23]);
                default: lvl[2] = 1'b1;
            endcase
        end else begin
            unique case (st.pin_b_select)
                2'h0: begin
                    is_pulse[1] = 1'b0;
                    lvl[1] = ~(total_i.act[23] | total_i.react[23]);
                end
                2'h1: val[1] = total_i.app;
                default: is_pulse[1] = 1'b0;
            endcase
            unique case (st.pin_c_select)
                2'h0: val[2] = react_nz;
                2'h1: begin
                    is_pulse[2] = 1'b0;
                    lvl[2] = ~low_supply_i;
                end
                2'h2: begin
                    is_pulse[2] = 1'b0;
                    lvl[2] = ~samples_i.v1[23];
                end
                2'h3: val[2] = total_i.app;
            endcase
        end
    end

    // per-sample increment: |value| * rate / 2, overflow of the 2^23 point emits a pulse
    for (genvar p = 0; p < 3; p++) begin : g_pin
        logic [22:0] mag;
        logic [45:0] prod;
        assign mag = val[p][23] ? 23'(-val[p]) : val[p][22:0];
        assign prod = mag * st.full_scale_rate_setting[22:0];
        assign inc[p] = prod[45:24];
    end

    // ************************************************************
    // line detectors
    // ************************************************************
    epl_dip_detect u_volt1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .sample_i(samples_i.v1),
        .level_i(st.volt1_dip_level),
        .duration_i(st.volt1_dip_duration),
        .set_o(dip_set[0])
    );
    epl_dip_detect u_curr1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .sample_i(samples_i.i1),
        .level_i(st.curr1_loss_level),
        .duration_i(st.curr1_loss_duration),
        .set_o(dip_set[1])
    );
    assign dip_set[2] = 1'b0;

    // ************************************************************
    // main state
    // ************************************************************
    assign tick = (st.div == 16'(SAMPLE_DIV_P - 1));
    assign wr = cyc_i & stb_i & we_i & ~st.ack;
    assign temp_sum = {samples_i.temp_raw[23], samples_i.temp_raw}
                    + {st.temp_zero_offset[23], st.temp_zero_offset};
    // both operands widened first so the product keeps all 49 bits
    assign temp_prod = $signed({{24{temp_sum[24]}}, temp_sum})
                     * $signed({25'h0000000, st.temp_scale_gain});

    always_comb begin
        logic [23:0] sum;
        sum = 24'h000000;
        next_st = st;
        evt = 4'h0;
        next_st.div = tick ? 16'h0000 : st.div + 16'h0001;
        if (tick) begin
            for (int p = 0; p < 3; p++) begin
                sum = {1'b0, st.acc[p]} + {2'b00, inc[p]};
                next_st.acc[p] = is_pulse[p] ? sum[22:0] : 23'h000000;
                if (st.wcnt[p] != 24'h000000) begin
                    next_st.wcnt[p] = st.wcnt[p] - 24'h000001;
                end
                if (is_pulse[p] && sum[23] && st.wcnt[p] <= 24'h000001) begin
                    next_st.wcnt[p] = st.pulse_duration_setting;
                end
            end
            // positive zero crossing of volt1 ends one line period
            next_st.v1_neg = samples_i.v1[23];
            next_st.period = st.period + 16'h0001;
            if (st.v1_neg && !samples_i.v1[23]) begin
                next_st.period = 16'h0001;
                if (st.auto_freq_enable && st.period != 16'h0000) begin
                    next_st.ratio = 24'(24'h800000 / {8'h00, st.period});
                    evt[ST_FREQ_UPD] = 1'b1;
                end
            end
            if (st.temp_trigger == 3'h0) begin
                next_st.v2 = samples_i.v2;
            end
            unique case (st.temp_trigger)
                TRIG_START: next_st.temp_trigger = TRIG_MID;
                TRIG_MID: next_st.temp_trigger = TRIG_LAST;
                TRIG_LAST: begin
                    next_st.temp_trigger = 3'h0;
                    next_st.temp = temp_prod[40:17];
                    evt[ST_TEMP_UPD] = 1'b1;
                end
                default: next_st.temp_trigger = 3'h0;
            endcase
        end
        for (int p = 0; p < 3; p++) begin
            // steady-state pins drop any pulse in flight
            if (!is_pulse[p]) begin
                next_st.wcnt[p] = 24'h000000;
            end
            next_st.pins[p] = is_pulse[p] ? (next_st.wcnt[p] == 24'h000000) : lvl[p];
        end
        evt[ST_VOLT1_DIP] = dip_set[0];
        evt[ST_CURR1_LOSS] = dip_set[1];
        // ************************************************************
        // wishbone register access
        // ************************************************************
        next_st.ack = cyc_i & stb_i & ~st.ack;
        next_st.dat = 32'h00000000;
        if (cyc_i && stb_i && !st.ack) begin
            unique case (adr_i)
                OFF_MODES: next_st.dat = {25'h0000000, st.auto_freq_enable,
                    st.shared_pulse_select, st.pin_c_select, st.pin_b_select};
                OFF_NO_LOAD: next_st.dat = {8'h00, st.no_load_threshold};
                OFF_PULSE_DUR: next_st.dat = {8'h00, st.pulse_duration_setting};
                OFF_RATE: next_st.dat = {8'h00, st.full_scale_rate_setting};
                OFF_V1_DUR: next_st.dat = {8'h00, st.volt1_dip_duration};
                OFF_V1_LEV: next_st.dat = {8'h00, st.volt1_dip_level};
                OFF_I1_DUR: next_st.dat = {8'h00, st.curr1_loss_duration};
                OFF_I1_LEV: next_st.dat = {8'h00, st.curr1_loss_level};
                OFF_RATIO: next_st.dat = {8'h00, st.ratio};
                OFF_TRIG: next_st.dat = {29'h00000000, st.temp_trigger};
                OFF_TEMP: next_st.dat = {8'h00, st.temp};
                OFF_TEMP_GAIN: next_st.dat = {8'h00, st.temp_scale_gain};
                OFF_TEMP_OFFSET: next_st.dat = {8'h00, st.temp_zero_offset};
                OFF_STATUS: next_st.dat = {28'h0000000, st.status};
                OFF_V2: next_st.dat = {8'h00, st.v2};
                default: next_st.dat = 32'h00000000;
            endcase
        end
        if (wr) begin
            unique case (adr_i)
                OFF_MODES: begin
                    if (sel_i[0]) begin
                        next_st.pin_b_select = dat_i[MODES_PIN_B +: 2];
                        next_st.pin_c_select = dat_i[MODES_PIN_C +: 2];
                        next_st.shared_pulse_select = dat_i[MODES_SHARED +: 2];
                        next_st.auto_freq_enable = dat_i[MODES_AUTO_FREQ];
                    end
                end
                OFF_NO_LOAD: next_st.no_load_threshold = merge(st.no_load_threshold, dat_i, sel_i);
                OFF_PULSE_DUR: next_st.pulse_duration_setting =
                    merge(st.pulse_duration_setting, dat_i, sel_i);
                OFF_RATE: next_st.full_scale_rate_setting =
                    merge(st.full_scale_rate_setting, dat_i, sel_i);
                OFF_V1_DUR: next_st.volt1_dip_duration =
                    merge(st.volt1_dip_duration, dat_i, sel_i);
                OFF_V1_LEV: next_st.volt1_dip_level = merge(st.volt1_dip_level, dat_i, sel_i);
                OFF_I1_DUR: next_st.curr1_loss_duration =
                    merge(st.curr1_loss_duration, dat_i, sel_i);
                OFF_I1_LEV: next_st.curr1_loss_level = merge(st.curr1_loss_level, dat_i, sel_i);
                OFF_RATIO: next_st.ratio = merge(st.ratio, dat_i, sel_i);
                OFF_TRIG: begin
                    // restart ignored while a measurement runs
                    if (sel_i[0] && dat_i[2:0] == TRIG_START && st.temp_trigger == 3'h0) begin
                        next_st.temp_trigger = TRIG_START;
                    end
                end
                OFF_TEMP_GAIN: next_st.temp_scale_gain =
                    merge(st.temp_scale_gain, dat_i, sel_i);
                OFF_TEMP_OFFSET: next_st.temp_zero_offset =
                    merge(st.temp_zero_offset, dat_i, sel_i);
                OFF_STATUS: begin
                    if (sel_i[0]) begin
                        next_st.status = st.status & ~dat_i[3:0];
                    end
                end
                default: next_st.status = next_st.status;
            endcase
        end
        // a hardware event wins over a clear in the same cycle
        next_st.status = next_st.status | evt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.pins <= 3'b111;
            st.pulse_duration_setting <= RST_PULSE_DUR;
            st.ratio <= RST_RATIO;
            st.temp_scale_gain <= RST_TEMP_GAIN;
            st.temp_zero_offset <= RST_TEMP_OFFSET;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o = st.dat;
    assign ack_o = st.ack;
    assign pulse_pin_a_o = st.pins[0];
    assign pulse_pin_b_o = st.pins[1];
    assign pulse_pin_c_o = st.pins[2];
endmodule : epl_monitor

// ==== sim/epl_assertions.sv ====
// Purpose: bus and pin checks on the ports of epl_monitor
// Assumes: one clock, synchronous active-high reset
// Notes: tick length follows SAMPLE_DIV_P of the design
`timescale 1ns/100ps
module epl_assertions
    import epl_pkg::*;
#(
    parameter int SAMPLE_DIV_P = SAMPLE_DIV
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins
    input wire logic pulse_pin_a_o,
    input wire logic pulse_pin_b_o,
    input wire logic pulse_pin_c_o
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int low_cnt;
    // low time counted so pulse ends can be judged against whole ticks
    always_ff @(posedge clk_i) begin
        low_cnt <= (rst_i || pulse_pin_a_o) ? 0 : low_cnt + 1;
    end
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_rd_hole;
        cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'h3C;
    endsequence
    a_ack_follows: assert property (s_take |=> ack_o) else $error("ack missing");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
    a_hole_zero: assert property (s_rd_hole |=> ack_o && dat_o == 32'h0) else $error("hole data");
    a_upper_zero: assert property (ack_o |-> dat_o[31:24] == 8'h00) else $error("upper bits");
    a_pins_reset: assert property ($past(rst_i) |-> pulse_pin_a_o && pulse_pin_b_o
        && pulse_pin_c_o) else $error("pins low after reset");
    a_pulse_width: assert property ($rose(pulse_pin_a_o) |-> low_cnt != 0
        && low_cnt % SAMPLE_DIV_P == 0) else $error("pulse not whole ticks");
endmodule : epl_assertions
bind epl_monitor epl_assertions #(.SAMPLE_DIV_P(SAMPLE_DIV_P)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .pulse_pin_a_o(pulse_pin_a_o), .pulse_pin_b_o(pulse_pin_b_o),
    .pulse_pin_c_o(pulse_pin_c_o));

// ==== sim/epl_pulse_counter.sv ====
// Purpose: external counter on one active-low pulse pin
// Assumes: clr_i synchronous to clk_i
// Notes: counts falling edges only, steady levels are judged by the bench
`timescale 1ns/100ps
module epl_pulse_counter (
    // clock and clear
    input wire logic clk_i,
    input wire logic clr_i,
    // watched pin
    input wire logic pin_i,
    // tally
    output int count_o
);
    // ****
    // edge tally
    // ****
    logic last = 1'h1;
    always_ff @(posedge clk_i) begin
        last <= pin_i;
        if (clr_i) begin
            count_o <= 0;
        end else if (last && !pin_i) begin
            count_o <= count_o + 1;
        end
    end
endmodule : epl_pulse_counter

// ==== sim/epl_monitor_bench.sv ====
// Purpose: self-checking bench for epl_monitor
// Assumes: ticks shortened to 20 clocks
// Notes: pulse windows span whole accumulator periods, so counts are exact
`timescale 1ns/100ps
module epl_monitor_bench
    import epl_pkg::*;
;
    // ****
    // wiring and tasks
    // ****
    localparam int DIV = 20;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0, low_sup = 0;
    logic ack, pa, pb, pc;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, dr, rd, q, hist;
    epl_energy_t tot = '0, c1 = '0, c2 = '0;
    epl_samples_t smp = '0;
    int ca, cb, cc, e, fail_count = 0, num_checks = 0, cycles = 0;
    logic [7:0] ra [8] = '{OFF_MODES, OFF_PULSE_DUR, OFF_RATIO, OFF_TRIG, OFF_TEMP_GAIN,
        OFF_TEMP_OFFSET, OFF_STATUS, 8'h3C};
    logic [23:0] rv [8] = '{24'h0, 24'h1, 24'h19999, 24'h0, 24'h2F03C3, 24'hF3D35A, 24'h0, 24'h0};
    epl_monitor #(.SAMPLE_DIV_P(DIV)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dw), .dat_o(dr), .ack_o(ack),
        .total_i(tot), .ch1_i(c1), .ch2_i(c2), .samples_i(smp), .low_supply_i(low_sup),
        .pulse_pin_a_o(pa), .pulse_pin_b_o(pb), .pulse_pin_c_o(pc));
    epl_pulse_counter u_ca (.clk_i(clk_i), .clr_i(clr), .pin_i(pa), .count_o(ca));
    epl_pulse_counter u_cb (.clk_i(clk_i), .clr_i(clr), .pin_i(pb), .count_o(cb));
    epl_pulse_counter u_cc (.clk_i(clk_i), .clr_i(clr), .pin_i(pc), .count_o(cc));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dw <= d;
        do @(posedge clk_i); while (ack !== 1'h1);
        rd = dr;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic ticks(input int n);
        repeat (n * DIV) @(posedge clk_i);
    endtask : ticks
    // settle first, then count over exactly n ticks
    task automatic window(input int n);
        ticks(10);
        clr <= 1'h1;
        @(posedge clk_i);
        clr <= 1'h0;
        ticks(n);
        @(posedge clk_i);
    endtask : window
    // falls in n ticks at rate 0.5: per tick |v| * rate / 2 of a full count
    function automatic int pulses(input logic [23:0] v, input int n);
        return n * int'((longint'(v) * 64'h400000) >> 24) / 2 ** 23;
    endfunction : pulses
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ****
    // sequence
    // ****
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            bus(1'h0, ra[i], 32'h0);
            chk("reset value", rd, {8'h00, rv[i]});
        end
        tot <= {24'h400000, 24'h400000, 24'hF00000, 24'h0};
        ticks(1);
        chk("pin b sign", pb, 32'h0);
        $display("test reset done");
        tot <= {24'h400000, 24'h400000, 24'h200000, 24'h0};
        bus(1'h1, OFF_PULSE_DUR, 32'h2);
        bus(1'h1, OFF_RATE, 32'h400000);
        window(80);
        chk("pin a count", ca, pulses(24'h400000, 80));
        chk("pin c count", cc, pulses(24'h200000, 80));
        chk("pin b steady", cb, 32'h0);
        bus(1'h1, OFF_NO_LOAD, 32'h500000);
        window(80);
        chk("clamped", ca + cc, 32'h0);
        bus(1'h1, OFF_NO_LOAD, 32'h0);
        $display("test pulses done");
        for (int k = 0; k < 3; k++) begin
            bus(1'h1, OFF_MODES, k);
            window(80);
            chk("pin b select", cb, k == 1 ? pulses(24'h400000, 80) : 0);
        end
        low_sup <= 1'h1;
        smp <= {24'h100000, 24'h0, 24'h0, 24'h0};
        for (int k = 0; k < 4; k++) begin
            bus(1'h1, OFF_MODES, k << 2);
            window(80);
            e = k == 0 ? pulses(24'h200000, 80) : k == 3 ? pulses(24'h400000, 80) : 0;
            chk("pin c select", cc, e);
            if (k == 1 || k == 2) chk("pin c level", pc, k - 1);
        end
        $display("test selects done");
        c1 <= {24'h400000, 24'h200000, 24'h100000, 24'h080000};
        c2 <= {24'hC00000, 24'hE00000, 24'hF00000, 24'hF80000};
        for (int k = 0; k < 4; k++) begin
            bus(1'h1, OFF_MODES, 32'h7 | (k << 4));
            window(128);
            e = pulses(c1[95 - 24 * k -: 24], 128);
            chk("shared pin a", ca, e);
            chk("shared pin b", cb, e);
            chk("shared sign", pc, 32'h0);
        end
        low_sup <= 1'h0;
        bus(1'h1, OFF_MODES, 32'h3);
        ticks(1);
        chk("shared supply", pc, 32'h1);
        $display("test shared done");
        bus(1'h1, OFF_MODES, 32'h0);
        smp <= {24'h100000, 24'h0, 24'h111111, 24'h0E2CA6};
        ticks(2);
        bus(1'h1, OFF_TRIG, 32'h1);
        smp.v2 <= 24'h222222;
        hist = 32'h1;
        q = 32'h1;
        repeat (40) begin
            bus(1'h0, OFF_TRIG, 32'h0);
            if (rd !== q) hist = {hist[23:0], rd[7:0]};
            q = rd;
            // the last step may end the hold before the read lands
            if (q === 32'h1 || q === 32'h2) begin
                bus(1'h0, OFF_V2, 32'h0);
                chk("held volt2", rd, 32'h111111);
            end
        end
        chk("trigger steps", hist, 32'h01020400);
        bus(1'h0, OFF_TEMP, 32'h0);
        chk("temp result", rd, 32'h2F03C3);
        bus(1'h0, OFF_STATUS, 32'h0);
        chk("temp flag", rd[3], 32'h1);
        bus(1'h0, OFF_V2, 32'h0);
        chk("volt2 resumed", rd, 32'h222222);
        $display("test temperature done");
        bus(1'h1, OFF_V1_LEV, 32'h100000);
        bus(1'h1, OFF_I1_LEV, 32'h100000);
        bus(1'h1, OFF_V1_DUR, 32'h4);
        smp <= {24'hFF0000, 24'h000100, 24'h222222, 24'h0};
        ticks(12);
        bus(1'h0, OFF_STATUS, 32'h0);
        chk("dip flags", rd[1:0], 32'h1);
        smp.v1 <= 24'hC00000;
        ticks(12);
        bus(1'h1, OFF_STATUS, 32'h3);
        ticks(12);
        bus(1'h0, OFF_STATUS, 32'h0);
        chk("rectified dip", rd[1:0], 32'h0);
        $display("test dip done");
        // rising volt1 crossings 64 samples apart give a ratio of 1/64
        bus(1'h1, OFF_MODES, 32'h40);
        repeat (2) begin
            smp.v1 <= 24'h100000;
            ticks(32);
            smp.v1 <= 24'hF00000;
            ticks(32);
        end
        bus(1'h0, OFF_RATIO, 32'h0);
        chk("auto ratio", rd, 32'h20000);
        bus(1'h0, OFF_STATUS, 32'h0);
        chk("freq flag", rd[2], 32'h1);
        $display("test frequency done");
        end_of_test();
    end
endmodule : epl_monitor_bench
